//--- inc/pdt_defines.svh
// constants of the prescaled down timer: offsets, fields, reset values, counts
// assumes inclusion by bare name from the package and the design file
`ifndef PDT_DEFINES_SVH
`define PDT_DEFINES_SVH

// ------------------------------------------------------------
// bus geometry
// ------------------------------------------------------------
`define PDT_AXI_AW 12
`define PDT_AXI_DW 32
`define PDT_IDX_W 10
`define PDT_RESP_OKAY 2'h0
`define PDT_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define PDT_IDX_PRESCALER 10'h0d2
`define PDT_IDX_COUNT 10'h0d3
`define PDT_IDX_STATUS_CTRL 10'h0d4
`define PDT_IDX_EV_STATUS 10'h0d5
`define PDT_IDX_EV_CLEAR 10'h0d6
`define PDT_IDX_EV_ENABLE 10'h0d7

// ------------------------------------------------------------
// widths, reset values, field positions
// ------------------------------------------------------------
`define PDT_PSC_W 7
`define PDT_CNT_W 8
`define PDT_EV_W 2
`define PDT_RST_PSC 7'h7f
`define PDT_RST_CNT 8'hff
`define PDT_RST_CTRL 8'h00
`define PDT_ZERO_BIT 7
`define PDT_EV_UNDERFLOW 0
`define PDT_EV_PIN_EDGE 1
`define PDT_DIV_LAST 4'hb
`define PDT_TAPS 8

`endif

//--- inc/pdt_pkg.sv
// types shared by the prescaled down timer
// assumes the defines header is on the include path
`include "pdt_defines.svh"

package pdt_pkg;

    // status/control layout, bit 7 first
    typedef struct packed {
        logic zero_flag;
        logic irq_enable;
        logic pin_output_select;
        logic data_out;
        logic prescaler_init;
        logic [2:0] division_select;
    } pdt_ctrl_t;

    // a write held until both channels have arrived
    typedef struct packed {
        logic [`PDT_AXI_AW-1:0] addr;
        logic [7:0] data;
        logic strb;
    } pdt_wreq_t;

    // write channel sequencing
    typedef enum logic [1:0] {
        PDT_WR_IDLE = 2'b01,
        PDT_WR_RESP = 2'b10
    } pdt_wr_state_t;

endpackage

//--- rtl/pdt_timer.sv
// prescaled down timer: 7-bit prescaler, 8-bit down counter, pin and irq
// assumes one 40 MHz clock, pin input already synchronous to aclk
`timescale 1ns/100ps
`include "pdt_defines.svh"

module pdt_timer
    import pdt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`PDT_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`PDT_AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PDT_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`PDT_AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe,
    output logic irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    pdt_wr_state_t wr_state;
    pdt_wr_state_t next_wr_state;
    pdt_wreq_t wreq;
    pdt_ctrl_t ctrl;
    pdt_ctrl_t next_ctrl;
    logic aw_got;
    logic w_got;
    logic next_aw_got;
    logic next_w_got;
    logic do_write;
    logic wr_hit;
    logic [`PDT_IDX_W-1:0] wr_idx;
    logic [`PDT_IDX_W-1:0] rd_idx;
    logic next_rvalid;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic wr_psc;
    logic wr_cnt;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_enable;
    logic [3:0] div_cnt;
    logic tick12;
    logic pin_prev;
    logic pin_rise;
    logic clk_en;
    logic [`PDT_PSC_W-1:0] psc;
    logic [`PDT_PSC_W-1:0] psc_dec;
    logic [`PDT_TAPS-1:0] tap_hit;
    logic count_tick;
    logic [`PDT_CNT_W-1:0] cnt;
    logic underflow;
    logic [`PDT_EV_W-1:0] ev_status;
    logic [`PDT_EV_W-1:0] ev_enable;
    logic [`PDT_EV_W-1:0] ev_set;

    // ------------------------------------------------------------
    // write channels of the register bus
    // ------------------------------------------------------------
    assign wr_idx = wreq.addr[`PDT_AXI_AW-1:2];
    assign do_write = (wr_state == PDT_WR_IDLE) && aw_got && w_got;

    // next state of the write path, address and data in either order
    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_wr_state = wr_state;
        case (wr_state)
            PDT_WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    next_aw_got = 1'b1;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    next_w_got = 1'b1;
                end
                if (do_write) begin
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                    next_wr_state = PDT_WR_RESP;
                end
            end
            PDT_WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = PDT_WR_IDLE;
                end
            end
            default: begin
                next_wr_state = PDT_WR_IDLE;
            end
        endcase
    end

    // ready flags are registered so every output leaves a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= PDT_WR_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            wr_state <= next_wr_state;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            s_axi_awready <= (next_wr_state == PDT_WR_IDLE) && !next_aw_got;
            s_axi_wready <= (next_wr_state == PDT_WR_IDLE) && !next_w_got;
        end
    end

    // capture payloads; only the low byte lane carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreq <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wreq.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wreq.data <= s_axi_wdata[7:0];
                wreq.strb <= s_axi_wstrb[0];
            end
        end
    end

    // decode of the pending write
    always_comb begin
        wr_hit = 1'b1;
        case (wr_idx)
            `PDT_IDX_PRESCALER, `PDT_IDX_COUNT, `PDT_IDX_STATUS_CTRL: wr_hit = 1'b1;
            `PDT_IDX_EV_STATUS, `PDT_IDX_EV_CLEAR, `PDT_IDX_EV_ENABLE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    assign wr_psc = do_write && wreq.strb && (wr_idx == `PDT_IDX_PRESCALER);
    assign wr_cnt = do_write && wreq.strb && (wr_idx == `PDT_IDX_COUNT);
    assign wr_ctrl = do_write && wreq.strb && (wr_idx == `PDT_IDX_STATUS_CTRL);
    assign wr_clear = do_write && wreq.strb && (wr_idx == `PDT_IDX_EV_CLEAR);
    assign wr_enable = do_write && wreq.strb && (wr_idx == `PDT_IDX_EV_ENABLE);

    // write response, unmapped address answers slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDT_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PDT_RESP_OKAY : `PDT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read channel of the register bus
    // ------------------------------------------------------------
    assign rd_idx = s_axi_araddr[`PDT_AXI_AW-1:2];
    assign next_rvalid = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);

    // read mux; the clear register is write-only and reads zero
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            `PDT_IDX_PRESCALER: rd_byte = {1'b0, psc};
            `PDT_IDX_COUNT: rd_byte = cnt;
            `PDT_IDX_STATUS_CTRL: rd_byte = ctrl;
            `PDT_IDX_EV_STATUS: rd_byte = {6'h00, ev_status};
            `PDT_IDX_EV_CLEAR: rd_byte = 8'h00;
            `PDT_IDX_EV_ENABLE: rd_byte = {6'h00, ev_enable};
            default: rd_hit = 1'b0;
        endcase
    end

    // data sampled at acceptance, held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PDT_RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_hit ? `PDT_RESP_OKAY : `PDT_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // clock sources
    // ------------------------------------------------------------
    // internal clock divided by twelve as a one-cycle enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 4'h0;
            tick12 <= 1'b0;
        end else if (div_cnt == `PDT_DIV_LAST) begin
            div_cnt <= 4'h0;
            tick12 <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 4'h1;
            tick12 <= 1'b0;
        end
    end

    // pin history for edge counting; pin arrives already synchronous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= timer_pin_i;
        end
    end

    assign pin_rise = timer_pin_i && !pin_prev;

    // source select by output select and data out
    always_comb begin
        case ({ctrl.pin_output_select, ctrl.data_out})
            2'b00: clk_en = pin_rise;
            2'b01: clk_en = tick12 && timer_pin_i;
            default: clk_en = tick12;
        endcase
    end

    // ------------------------------------------------------------
    // prescaler and taps
    // ------------------------------------------------------------
    assign psc_dec = (psc == '0) ? `PDT_RST_PSC : psc - 7'h01;

    // tap 0 fires every step, tap n when prescaler bit n-1 falls: one pulse per 2^n steps
    assign tap_hit[0] = 1'b1;
    for (genvar g = 1; g < `PDT_TAPS; g++) begin : g_tap
        assign tap_hit[g] = psc[g-1] && !psc_dec[g-1];
    end

    assign count_tick = clk_en && ctrl.prescaler_init && tap_hit[ctrl.division_select];

    // direct prescaler writes only take effect while counting is enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc <= `PDT_RST_PSC;
        end else if (!ctrl.prescaler_init) begin
            psc <= `PDT_RST_PSC;
        end else if (wr_psc) begin
            psc <= wreq.data[`PDT_PSC_W-1:0];
        end else if (clk_en) begin
            psc <= psc_dec;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    assign underflow = count_tick && (cnt == '0) && !wr_cnt;

    // software write wins over a coinciding decrement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= `PDT_RST_CNT;
        end else if (wr_cnt) begin
            cnt <= wreq.data;
        end else if (count_tick) begin
            cnt <= (cnt == '0) ? `PDT_RST_CNT : cnt - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // status/control
    // ------------------------------------------------------------
    // set from underflow, writing 00h to the counter, or writing bit 7 high
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = wreq.data;
        end
        if (underflow || (wr_cnt && wreq.data == 8'h00)) begin
            next_ctrl.zero_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `PDT_RST_CTRL;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // pin driver: latch data out on the zero flag's rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_pin_o <= 1'b0;
            timer_pin_oe <= 1'b0;
        end else begin
            timer_pin_oe <= next_ctrl.pin_output_select;
            if (!ctrl.zero_flag && next_ctrl.zero_flag) begin
                timer_pin_o <= ctrl.data_out;
            end
        end
    end

    // ------------------------------------------------------------
    // event status, clear, enable and interrupt
    // ------------------------------------------------------------
    assign ev_set[`PDT_EV_UNDERFLOW] = underflow;
    assign ev_set[`PDT_EV_PIN_EDGE] = pin_rise && !ctrl.pin_output_select;

    // sticky bits; a set in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_status <= '0;
            ev_enable <= '0;
        end else begin
            ev_status <= (ev_status & ~(wr_clear ? wreq.data[`PDT_EV_W-1:0] : 2'h0)) | ev_set;
            if (wr_enable) begin
                ev_enable <= wreq.data[`PDT_EV_W-1:0];
            end
        end
    end

    // one level output, gated by the irq enable bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_ctrl.irq_enable && (next_ctrl.zero_flag || |(ev_status & ev_enable));
        end
    end

endmodule

//--- tb/pdt_timer_assertions.sv
// checker of the timer's bus handshakes, pin enable and interrupt level
// assumes it is bound to pdt_timer and sees only that module's ports
`timescale 1ns/100ps
`include "pdt_defines.svh"
module pdt_timer_checker
    import pdt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`PDT_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [`PDT_AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PDT_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`PDT_AXI_DW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_pin_i,
    input wire logic timer_pin_o,
    input wire logic timer_pin_oe,
    input wire logic irq
);
    // ------------------------------------------------------------
    // shadows of the transfers in flight
    // ------------------------------------------------------------
    logic [9:0] ar_idx;
    logic [9:0] aw_idx;
    logic [7:0] w_byte;
    logic en_sh;
    // read index, kept for the decode checks
    always_ff @(posedge aclk) begin
        if (!aresetn) ar_idx <= 10'h0;
        else if (s_axi_arvalid && s_axi_arready) ar_idx <= s_axi_araddr[11:2];
    end
    // write index and byte, each captured as its channel is taken
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_idx <= s_axi_awaddr[11:2];
        if (s_axi_wvalid && s_axi_wready) w_byte <= s_axi_wdata[7:0];
    end
    // enable as last written; moves only at the answer, so mid-write cycles stay out
    always_ff @(posedge aclk) begin
        if (!aresetn) en_sh <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready && aw_idx == `PDT_IDX_STATUS_CTRL) en_sh <= w_byte[6];
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_rdata_high; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rdata_high: assert property (p_rdata_high) else $error("read data above low byte not zero");
    property p_psc_top; s_axi_rvalid && ar_idx == `PDT_IDX_PRESCALER |-> !s_axi_rdata[7]; endproperty
    a_psc_top: assert property (p_psc_top) else $error("prescaler top bit read as one");
    property p_unmapped;
        s_axi_rvalid && (ar_idx < `PDT_IDX_PRESCALER || ar_idx > `PDT_IDX_EV_ENABLE)
            |-> s_axi_rresp == `PDT_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped or changed");
    property p_ar_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_ar_lat: assert property (p_ar_lat) else $error("read answer late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped or changed");
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer not two edges after");
    property p_oe; s_axi_bvalid && s_axi_bready && aw_idx == `PDT_IDX_STATUS_CTRL |-> timer_pin_oe == w_byte[5]; endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from output select");
    property p_irq_gate; !en_sh && s_axi_awready |-> !irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq high with enable clear");
    property p_irq_hold; irq && s_axi_awready |=> irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq fell without a write");
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `PDT_RESP_SLVERR);
    c_irq: cover property ($rose(irq));
    c_oe: cover property ($rose(timer_pin_oe));
endmodule

//--- tb/pdt_pin_model.sv
// far side of the timer pin: an external pulse source
// assumes the timer's clock; the bench asks for pulse trains
`timescale 1ns/100ps
module pdt_pin_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [8:0] pulses,
    input wire logic go,
    input wire logic level,
    input wire logic timer_pin_o,
    input wire logic timer_pin_oe,
    output logic timer_pin_i,
    output logic busy
);
    logic [10:0] ph;
    // two cycles high, two low: one rising edge per pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph <= 11'h0;
            busy <= 1'b0;
        end else if (go && !busy) begin
            ph <= {pulses, 2'b00};
            busy <= (pulses != 9'h0);
        end else if (busy) begin
            ph <= ph - 11'h1;
            busy <= (ph != 11'h1);
        end
    end
    // push-pull output wins the wire while enabled
    assign timer_pin_i = timer_pin_oe ? timer_pin_o : (busy ? ph[1] : level);
endmodule

//--- tb/pdt_timer_bench.sv
// self-checking bench of the prescaled down timer over its register bus
// assumes the pin model on the far side and the checker bound below
`timescale 1ns/100ps
`include "pdt_defines.svh"
module pdt_timer_bench
    import pdt_pkg::*;
;
    localparam logic [11:0] adr_psc = {`PDT_IDX_PRESCALER, 2'b00};
    localparam logic [11:0] adr_cnt = {`PDT_IDX_COUNT, 2'b00};
    localparam logic [11:0] adr_ctl = {`PDT_IDX_STATUS_CTRL, 2'b00};
    localparam logic [11:0] adr_evs = {`PDT_IDX_EV_STATUS, 2'b00};
    localparam logic [11:0] adr_evc = {`PDT_IDX_EV_CLEAR, 2'b00};
    localparam logic [11:0] adr_eve = {`PDT_IDX_EV_ENABLE, 2'b00};
    localparam logic [11:0] adr_bad = 12'h360;
    localparam logic [1:0] ok = `PDT_RESP_OKAY;
    localparam logic [1:0] err = `PDT_RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, level = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rs = 32'h46b57f04, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [8:0] pulses = 9'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic timer_pin_i, timer_pin_o, timer_pin_oe, irq, busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] rq[$];
    logic [1:0] bq[$];
    int err_total = 0, checked = 0;
    pdt_timer i_pdt_timer (.*);
    pdt_pin_model i_pdt_pin_model (.*);
    always #12.5 aclk = ~aclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // pins looked at mid-cycle, where the edge's updates have landed
    task automatic chk_pins(input logic [2:0] e);
        @(negedge aclk);
        cmp_w("irq_pin_o_oe", {29'h0, e}, {29'h0, irq, timer_pin_o, timer_pin_oe});
        @(posedge aclk);
    endtask
    // read; a random stall on rready exercises the held answer
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        rs = lfsr(rs);
        repeat (rs[1:0]) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        bq.push_back(r);
        rs = lfsr(rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= {rs[31:8], d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge aclk);
            if (s_axi_awready && !ga) begin
                ga = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !gw) begin
                gw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat ({rs[1:0], 1'b0}) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic pulse(input logic [8:0] p);
        pulses <= p;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do @(posedge aclk); while (busy);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // answers checked against the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            cmp_w("rdata", {24'h0, rq[0][7:0]}, s_axi_rdata);
            cmp_w("rresp", {30'h0, rq[0][9:8]}, {30'h0, s_axi_rresp});
            void'(rq.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) begin
            cmp_w("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
        end
    end
    // whole run is some 3000 cycles
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        $display("FAIL watchdog expected end seen timeout");
        test_done();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(adr_psc, 8'h7f, ok);
        rd(adr_cnt, 8'hff, ok);
        rd(adr_ctl, 8'h00, ok);
        rd(adr_evs, 8'h00, ok);
        rd(adr_eve, 8'h00, ok);
        rd(adr_bad, 8'h00, err);
        wr(adr_bad, 8'h55, err);
        chk_pins(3'b000);
        $display("test reset values done");
        v = rs;
        wr(adr_ctl, 8'h08, ok);
        wr(adr_psc, v[7:0], ok);
        rd(adr_psc, {1'b0, v[6:0]}, ok);
        wr(adr_cnt, v[15:8] | 8'h80, ok);
        rd(adr_cnt, v[15:8] | 8'h80, ok);
        wr(adr_ctl, 8'h5f, ok);
        rd(adr_ctl, 8'h5f, ok);
        chk_pins(3'b000);
        wr(adr_ctl, 8'h00, ok);
        rd(adr_psc, 8'h7f, ok);
        wr(adr_psc, 8'h12, ok);
        rd(adr_psc, 8'h7f, ok);
        // low lane strobe off: the counter write must be dropped
        s_axi_wstrb <= 4'he;
        wr(adr_cnt, 8'h11, ok);
        s_axi_wstrb <= 4'hf;
        rd(adr_cnt, v[15:8] | 8'h80, ok);
        chk_pins(3'b000);
        $display("test register access done");
        // 2^(n+1) pin events give two counter steps at every tap
        for (int n = 0; n < 8; n++) begin
            wr(adr_ctl, 8'h00, ok);
            wr(adr_cnt, 8'hff, ok);
            wr(adr_ctl, 8'h08 | 8'(n), ok);
            pulse(9'(2 << n));
            rd(adr_cnt, 8'hfd, ok);
            rd(adr_psc, {1'b0, 7'(7'h7f - (2 << n))}, ok);
        end
        $display("test division taps done");
        rd(adr_evs, 8'h02, ok);
        wr(adr_eve, 8'h02, ok);
        rd(adr_eve, 8'h02, ok);
        wr(adr_ctl, 8'h48, ok);
        chk_pins(3'b100);
        wr(adr_ctl, 8'h08, ok);
        chk_pins(3'b000);
        wr(adr_ctl, 8'h48, ok);
        wr(adr_evc, 8'h02, ok);
        chk_pins(3'b000);
        rd(adr_evs, 8'h00, ok);
        rd(adr_evc, 8'h00, ok);
        $display("test event interrupt done");
        wr(adr_ctl, 8'h00, ok);
        wr(adr_eve, 8'h01, ok);
        wr(adr_cnt, 8'h02, ok);
        wr(adr_ctl, 8'h78, ok);
        chk_pins(3'b001);
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge aclk);
        chk_pins(3'b111);
        rd(adr_ctl, 8'hf8, ok);
        rd(adr_evs, 8'h01, ok);
        repeat (100) @(posedge aclk);
        chk_pins(3'b111);
        wr(adr_ctl, 8'h38, ok);
        chk_pins(3'b011);
        rd(adr_ctl, 8'h38, ok);
        $display("test underflow done");
        wr(adr_ctl, 8'h00, ok);
        wr(adr_ctl, 8'h18, ok);
        repeat (60) @(posedge aclk);
        rd(adr_psc, 8'h7f, ok);
        // pin high for 48 edges: exactly four divided ticks get through
        level <= 1'b1;
        repeat (48) @(posedge aclk);
        level <= 1'b0;
        rd(adr_psc, 8'h7b, ok);
        $display("test gated hold done");
        test_done();
    end
endmodule
bind pdt_timer pdt_timer_checker i_pdt_timer_checker (.*);
